// ---- rtl/san_pkg.sv ----
package san_pkg;
	localparam int REG_ADDR_W = 5;
	localparam int REG_DATA_W = 16;

	// Management register addresses
	localparam logic [4:0] ADDR_ADVERTISE = 5'h04;
	localparam logic [4:0] ADDR_PARTNER = 5'h05;
	localparam logic [4:0] ADDR_EXPANSION = 5'h06;
	localparam logic [4:0] ADDR_NP_TX = 5'h07;
	localparam logic [4:0] ADDR_NP_RX = 5'h08;

	// Ability word field positions, shared by advertise and partner
	localparam int BIT_LINK = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_DUPLEX = 12;
	localparam int BIT_SPEED_HI = 11;
	localparam int BIT_SPEED_LO = 10;
	localparam int BIT_ALWAYS_ONE = 0;

	// Speed codes
	localparam logic [1:0] SPEED_10M = 2'h0;
	localparam logic [1:0] SPEED_100M = 2'h1;
	localparam logic [1:0] SPEED_1G = 2'h2;
	localparam logic [1:0] SPEED_RSVD = 2'h3;

	// Expansion field positions
	localparam int BIT_NP_ABLE = 2;
	localparam int BIT_PAGE_RCVD = 1;

	// Next page field positions
	localparam int BIT_NP_MORE = 15;
	localparam int BIT_NP_MSG = 13;
	localparam int BIT_NP_COMPLY = 12;
	localparam int BIT_NP_TOGGLE = 11;
	localparam int BIT_NP_CODE_HI = 10;

	// Fixed and reset values
	localparam logic [15:0] ADV_MAC_VALUE = 16'h4001;
	localparam logic [15:0] PARTNER_RESET = 16'h8001;
	localparam logic [15:0] NP_TX_RESET = 16'h2001;
	localparam logic [15:0] NP_RX_RESET = 16'h0000;
	localparam logic [10:0] NP_NULL_CODE = 11'h001;
	localparam logic [15:0] EXP_CONST = 16'h0004;
	localparam logic [15:0] ADV_PHY_RMASK = 16'hDC00;
	localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;
	localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;
endpackage

// ---- rtl/san_regs.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - MAC mode: advertise register is read-only, returns fixed SGMII word.
// - PHY mode: advertise bit 15 is writable link status, resets zero.
// - PHY mode: advertise bit 14 is writable acknowledge, resets zero.
// - PHY mode: bit 12 duplex and bits 11:10 speed writable, reset zero.
// - PHY mode: bit 13 and bits 9:1 read zero; bit 0 reads one.
// - Partner register read-only: link, ack, duplex, speed from partner page.
// - Partner register bit 13 and 9:1 read zero, bit 0 reads one.
// - Page-received bit sets on new page, clears on read, resets zero.
// - Expansion next-page-able reads one; bits other than it and page-received read zero.
// - Next page transmit holds more, msg, comply, code fields as writable.
// - Next page transmit toggle is read-only, resets zero, alternates.
// - Without next page support, next page transmit reads defaults.
// - Next page receive is read-only, resets zero, holds partner page.
module san_regs
	import san_pkg::*;
#(
	parameter bit NP_ENABLE = 1'b0
) (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic MAC_MODE_I,
	input wire logic [REG_ADDR_W-1:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic [REG_DATA_W-1:0] REG_WDATA_I,
	input wire logic REG_RD_I,
	output logic [REG_DATA_W-1:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	input wire logic PAGE_RX_I,
	input wire logic PAGE_NEXT_I,
	input wire logic [REG_DATA_W-1:0] PAGE_WORD_I,
	input wire logic NP_SENT_I,
	output logic [REG_DATA_W-1:0] ADV_WORD_O,
	output logic [REG_DATA_W-1:0] NP_TX_WORD_O
);

	////////////////////////////////////////////////////////////////////////
	logic adv_link;
	logic adv_ack;
	logic adv_duplex;
	logic [1:0] adv_speed;
	logic [15:0] partner;
	logic page_rcvd;
	logic [15:0] np_tx;
	logic [15:0] np_rx;
	logic wr_adv;
	logic wr_np_tx;
	logic rd_exp;
	logic [15:0] adv_word;
	logic [15:0] np_tx_view;
	logic [15:0] next_rdata;

	// Writes to unmapped or read-only words decode to nothing at all
	assign wr_adv = REG_WR_I && (REG_ADDR_I == ADDR_ADVERTISE) && !MAC_MODE_I;
	assign wr_np_tx = REG_WR_I && (REG_ADDR_I == ADDR_NP_TX);
	assign rd_exp = REG_RD_I && (REG_ADDR_I == ADDR_EXPANSION);

	////////////////////////////////////////////////////////////////////////
	// Advertised fields; MAC mode blocks every write
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			adv_link <= 1'b0;
			adv_ack <= 1'b0;
			adv_duplex <= 1'b0;
			adv_speed <= SPEED_10M;
		end else if (wr_adv) begin
			adv_link <= REG_WDATA_I[BIT_LINK];
			adv_ack <= REG_WDATA_I[BIT_ACK];
			adv_duplex <= REG_WDATA_I[BIT_DUPLEX];
			adv_speed <= REG_WDATA_I[BIT_SPEED_HI:BIT_SPEED_LO];
		end
	end

	always_comb begin
		adv_word = 16'h0000;
		if (MAC_MODE_I) begin
			adv_word = ADV_MAC_VALUE;
		end else begin
			adv_word[BIT_LINK] = adv_link;
			adv_word[BIT_ACK] = adv_ack;
			adv_word[BIT_DUPLEX] = adv_duplex;
			adv_word[BIT_SPEED_HI:BIT_SPEED_LO] = adv_speed;
			adv_word[BIT_ALWAYS_ONE] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Partner pages; only the arriving page updates them, never a write
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			partner <= PARTNER_RESET;
		end else if (PAGE_RX_I && !PAGE_NEXT_I) begin
			partner <= (PAGE_WORD_I & ADV_PHY_RMASK) | 16'h0001;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			np_rx <= NP_RX_RESET;
		end else if (PAGE_RX_I && PAGE_NEXT_I) begin
			np_rx <= PAGE_WORD_I;
		end
	end

	// A page landing in the read cycle keeps the flag set
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			page_rcvd <= 1'b0;
		end else if (PAGE_RX_I) begin
			page_rcvd <= 1'b1;
		end else if (rd_exp) begin
			page_rcvd <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next page transmit; toggle is owned by hardware only
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			np_tx <= NP_TX_RESET;
		end else begin
			if (wr_np_tx) begin
				np_tx[BIT_NP_MORE] <= REG_WDATA_I[BIT_NP_MORE];
				np_tx[BIT_NP_MSG] <= REG_WDATA_I[BIT_NP_MSG];
				np_tx[BIT_NP_COMPLY] <= REG_WDATA_I[BIT_NP_COMPLY];
				np_tx[BIT_NP_CODE_HI:0] <= REG_WDATA_I[BIT_NP_CODE_HI:0];
			end
			if (NP_ENABLE && NP_SENT_I) begin
				np_tx[BIT_NP_TOGGLE] <= !np_tx[BIT_NP_TOGGLE];
			end
		end
	end

	// Unsupported next page: software sees defaults whatever it wrote
	assign np_tx_view = NP_ENABLE ? np_tx : NP_TX_RESET;

	////////////////////////////////////////////////////////////////////////
	// Read port; data comes one cycle after the strobe
	always_comb begin
		next_rdata = UNMAPPED_VALUE;
		case (REG_ADDR_I)
			ADDR_ADVERTISE: next_rdata = adv_word;
			ADDR_PARTNER: next_rdata = partner;
			ADDR_EXPANSION: begin
				next_rdata = EXP_CONST;
				next_rdata[BIT_PAGE_RCVD] = page_rcvd;
			end
			ADDR_NP_TX: next_rdata = np_tx_view;
			ADDR_NP_RX: next_rdata = np_rx;
			default: next_rdata = UNMAPPED_VALUE;
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			REG_RDATA_O <= 16'h0000;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I) begin
				REG_RDATA_O <= next_rdata;
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			ADV_WORD_O <= 16'h0000;
			NP_TX_WORD_O <= NP_TX_RESET;
		end else begin
			ADV_WORD_O <= adv_word;
			NP_TX_WORD_O <= np_tx_view;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	sequence s_rd(logic [4:0] a);
		REG_RD_I && (REG_ADDR_I == a);
	endsequence

	sequence s_wr(logic [4:0] a);
		REG_WR_I && (REG_ADDR_I == a);
	endsequence

	sequence s_page(logic nxt);
		PAGE_RX_I && (PAGE_NEXT_I == nxt);
	endsequence

	mac_adv_fixed_a: assert property (
		(s_rd(ADDR_ADVERTISE) and MAC_MODE_I) |=> REG_RDATA_O == ADV_MAC_VALUE)
		else $error("MAC advertise word not fixed");

	phy_adv_write_a: assert property (
		(s_wr(ADDR_ADVERTISE) and !MAC_MODE_I) ##1
		(s_rd(ADDR_ADVERTISE) and !MAC_MODE_I && !REG_WR_I)
		|=> REG_RDATA_O[15:10] == ($past(REG_WDATA_I, 2) & 16'hDC00) >> 10)
		else $error("PHY advertise write not read back");

	phy_adv_const_a: assert property (
		(s_rd(ADDR_ADVERTISE) and !MAC_MODE_I) |=>
		REG_RDATA_O[13] == 1'b0 && REG_RDATA_O[9:1] == 9'h000 &&
		REG_RDATA_O[0] == 1'b1)
		else $error("PHY advertise constant bits wrong");

	partner_load_a: assert property (
		s_page(1'b0) |=>
		partner[BIT_LINK] == $past(PAGE_WORD_I[BIT_LINK]) &&
		partner[BIT_ACK] == $past(PAGE_WORD_I[BIT_ACK]) &&
		partner[BIT_DUPLEX] == $past(PAGE_WORD_I[BIT_DUPLEX]) &&
		partner[BIT_SPEED_HI:BIT_SPEED_LO] ==
		$past(PAGE_WORD_I[BIT_SPEED_HI:BIT_SPEED_LO]))
		else $error("Partner ability not loaded from page");

	partner_const_a: assert property (
		s_rd(ADDR_PARTNER) |=> REG_RDATA_O[13] == 1'b0 &&
		REG_RDATA_O[9:0] == 10'h001)
		else $error("Partner constant bits wrong");

	page_flag_clear_a: assert property (
		(s_rd(ADDR_EXPANSION) and !PAGE_RX_I) |=> !page_rcvd)
		else $error("Page received not cleared on read");

	page_flag_set_a: assert property (
		PAGE_RX_I |=> page_rcvd)
		else $error("Page received not set");

	exp_const_a: assert property (
		s_rd(ADDR_EXPANSION) |=> (REG_RDATA_O & 16'hFFFD) == EXP_CONST)
		else $error("Expansion constant bits wrong");

	np_toggle_a: assert property (
		NP_ENABLE && NP_SENT_I |=> np_tx[BIT_NP_TOGGLE] !=
		$past(np_tx[BIT_NP_TOGGLE]))
		else $error("Toggle did not alternate");

	np_tx_default_a: assert property (
		(s_rd(ADDR_NP_TX) and !NP_ENABLE) |=> REG_RDATA_O == NP_TX_RESET)
		else $error("Next page transmit not at default");

	np_rx_load_a: assert property (
		s_page(1'b1) |=> np_rx == $past(PAGE_WORD_I))
		else $error("Next page receive not loaded");

	ro_write_a: assert property (
		(REG_WR_I && !PAGE_RX_I) |=> $stable(partner) && $stable(np_rx))
		else $error("Write changed a read-only register");

	mac_no_write_a: assert property (
		(s_wr(ADDR_ADVERTISE) and MAC_MODE_I) |=>
		$stable(adv_link) && $stable(adv_ack) && $stable(adv_speed) &&
		$stable(adv_duplex))
		else $error("MAC mode write changed advertise fields");

	// Read checks look one cycle back, since read data is registered
	np_rx_read_a: assert property (
		s_rd(ADDR_NP_RX) |=> REG_RDATA_O == $past(np_rx))
		else $error("Next page receive read wrong");

	partner_read_a: assert property (
		s_rd(ADDR_PARTNER) |=> REG_RDATA_O == $past(partner))
		else $error("Partner ability read wrong");

	exp_read_flag_a: assert property (
		s_rd(ADDR_EXPANSION) |=>
		REG_RDATA_O[BIT_PAGE_RCVD] == $past(page_rcvd))
		else $error("Page received not reported on read");

	// Copies handed to the negotiation engine lag the fields by one cycle
	mac_adv_out_a: assert property (
		MAC_MODE_I |=> ADV_WORD_O == ADV_MAC_VALUE)
		else $error("MAC advertise copy not fixed");

	adv_phy_out_a: assert property (
		!MAC_MODE_I |=>
		ADV_WORD_O[BIT_LINK] == $past(adv_link) &&
		ADV_WORD_O[BIT_ACK] == $past(adv_ack) &&
		ADV_WORD_O[BIT_SPEED_HI:BIT_SPEED_LO] == $past(adv_speed))
		else $error("Advertise copy does not follow fields");

	np_tx_out_default_a: assert property (
		!NP_ENABLE |-> NP_TX_WORD_O == NP_TX_RESET)
		else $error("Next page transmit copy not at default");

	// Toggle is owned by hardware; a write must never move it
	np_toggle_hold_a: assert property (
		!(NP_ENABLE && NP_SENT_I) |=> $stable(np_tx[BIT_NP_TOGGLE]))
		else $error("Toggle moved without a sent page");

	np_tx_write_a: assert property (
		s_wr(ADDR_NP_TX) |=>
		np_tx[BIT_NP_MORE] == $past(REG_WDATA_I[BIT_NP_MORE]) &&
		np_tx[BIT_NP_MSG] == $past(REG_WDATA_I[BIT_NP_MSG]) &&
		np_tx[BIT_NP_COMPLY] == $past(REG_WDATA_I[BIT_NP_COMPLY]) &&
		np_tx[BIT_NP_CODE_HI:0] ==
		$past(REG_WDATA_I[BIT_NP_CODE_HI:0]))
		else $error("Next page transmit fields not written");

	// Bit between more-pages and message select is reserved
	np_tx_rsvd_a: assert property (
		s_wr(ADDR_NP_TX) |=> np_tx[BIT_NP_MORE-1] == 1'b0)
		else $error("Next page transmit reserved bit set");

endmodule

// ---- tb/san_link_peer.sv ----
`timescale 1ns/1ps
// Far-side core: hands over one received page as a one-cycle pulse
module san_link_peer (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic next_i,
	input wire logic [15:0] word_i,
	output logic page_rx_o,
	output logic page_next_o,
	output logic [15:0] page_word_o
);
	initial begin
		page_rx_o = 1'b0;
		page_next_o = 1'b0;
		page_word_o = 16'h0000;
	end
	// Word is only valid with the pulse; invert it after so no stale value
	// can pass for a fresh page
	always @(posedge clk_i) begin
		page_rx_o <= send_i;
		page_next_o <= next_i;
		if (send_i) begin
			page_word_o <= word_i;
		end else begin
			page_word_o <= ~page_word_o;
		end
	end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
	import san_pkg::*;
	logic clk, rst, mac, wr_s, rd_s, np_sent, snd, nxt, prx, pnx;
	logic [4:0] addr;
	logic [15:0] wd, rdat, adv, nptx, sw, pw, rdat_np, nptx_np;
	logic rv;
	int error_cnt = 0;
	int tests_run = 0;
	logic [15:0] tbl [4] = '{16'hFFFF, 16'h0400, 16'h1800, 16'hA000};
	san_regs i_dut (.MCLK_I(clk), .RST_I(rst), .MAC_MODE_I(mac),
		.REG_ADDR_I(addr), .REG_WR_I(wr_s), .REG_WDATA_I(wd),
		.REG_RD_I(rd_s), .REG_RDATA_O(rdat), .REG_RVALID_O(rv),
		.PAGE_RX_I(prx), .PAGE_NEXT_I(pnx), .PAGE_WORD_I(pw),
		.NP_SENT_I(np_sent), .ADV_WORD_O(adv), .NP_TX_WORD_O(nptx));
	san_link_peer i_peer (.clk_i(clk), .send_i(snd), .next_i(nxt),
		.word_i(sw), .page_rx_o(prx), .page_next_o(pnx), .page_word_o(pw));
	// Second copy with next page on, so stored fields and toggle show
	san_regs #(.NP_ENABLE(1'b1)) i_dut_np (.MCLK_I(clk), .RST_I(rst),
		.MAC_MODE_I(mac), .REG_ADDR_I(addr), .REG_WR_I(wr_s),
		.REG_WDATA_I(wd), .REG_RD_I(rd_s), .REG_RDATA_O(rdat_np),
		.REG_RVALID_O(), .PAGE_RX_I(prx), .PAGE_NEXT_I(pnx),
		.PAGE_WORD_I(pw), .NP_SENT_I(np_sent), .ADV_WORD_O(),
		.NP_TX_WORD_O(nptx_np));
	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("errors %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data is taken with the valid pulse, waited for under a bound
	task automatic rd(logic [4:0] a, logic [15:0] e);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		while (rv !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (rv !== 1'b1) begin
			error_cnt++;
			test_done();
		end
		chk("read data", rdat, e);
	endtask
	// Write then read with no idle cycle between them
	task automatic wrrd(logic [4:0] a, logic [15:0] d, logic [15:0] e);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("read valid", {15'h0000, rv}, 16'h0001);
		chk("write then read", rdat, e);
	endtask
	task automatic page(logic np, logic [15:0] w);
		@(posedge clk);
		snd <= 1'b1;
		nxt <= np;
		sw <= w;
		@(posedge clk);
		snd <= 1'b0;
		nxt <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		mac = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		np_sent = 1'b0;
		snd = 1'b0;
		nxt = 1'b0;
		addr = 5'h00;
		wd = 16'h0000;
		sw = 16'h0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_ADVERTISE, 16'h0001);
		rd(ADDR_PARTNER, 16'h8001);
		rd(ADDR_EXPANSION, 16'h0004);
		rd(ADDR_NP_TX, 16'h2001);
		chk("np tx read", rdat_np, 16'h2001);
		chk("np tx word", nptx, 16'h2001);
		rd(ADDR_NP_RX, 16'h0000);
		rd(5'h1F, 16'h0000);
		wrrd(ADDR_ADVERTISE, 16'h5C00, 16'h5C01);
		// Every speed code, duplex, link, ack and the dead bit 13
		foreach (tbl[k]) begin
			wr(ADDR_ADVERTISE, tbl[k]);
			rd(ADDR_ADVERTISE, (tbl[k] & 16'hDC00) | 16'h0001);
		end
		chk("adv word", adv, 16'h8001);
		@(posedge clk);
		mac <= 1'b1;
		rd(ADDR_ADVERTISE, 16'h4001);
		wr(ADDR_ADVERTISE, 16'h0000);
		repeat (2) @(posedge clk);
		chk("adv word", adv, 16'h4001);
		mac <= 1'b0;
		rd(ADDR_ADVERTISE, 16'h8001);
		wr(ADDR_PARTNER, 16'hFFFF);
		wr(ADDR_EXPANSION, 16'hFFFF);
		wr(ADDR_NP_RX, 16'hFFFF);
		wr(ADDR_NP_TX, 16'h5A5A);
		rd(ADDR_PARTNER, 16'h8001);
		rd(ADDR_EXPANSION, 16'h0004);
		rd(ADDR_NP_RX, 16'h0000);
		rd(ADDR_NP_TX, 16'h2001);
		chk("np tx stored", rdat_np, 16'h125A);
		@(posedge clk);
		np_sent <= 1'b1;
		@(posedge clk);
		np_sent <= 1'b0;
		rd(ADDR_NP_TX, 16'h2001);
		chk("np tx toggled", rdat_np, 16'h1A5A);
		chk("np tx word", nptx_np, 16'h1A5A);
		chk("np tx word", nptx, 16'h2001);
		page(1'b0, 16'hFFFF);
		rd(ADDR_PARTNER, 16'hDC01);
		rd(ADDR_EXPANSION, 16'h0006);
		rd(ADDR_EXPANSION, 16'h0004);
		page(1'b1, 16'hA5A5);
		rd(ADDR_NP_RX, 16'hA5A5);
		rd(ADDR_PARTNER, 16'hDC01);
		test_done();
	end
endmodule
